/* File: hw/dctp_timer_port.sv */
// dual 8-bit counter timer with six three-state outputs, AXI4-Lite top
`timescale 1ns/1ps
`default_nettype none

module dctp_timer_port
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire dctp_pkg::dctp_addr_t   awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire dctp_pkg::dctp_data_t   wdata,
	input  wire dctp_pkg::dctp_strb_t   wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire dctp_pkg::dctp_addr_t   araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output dctp_pkg::dctp_data_t        rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	input  wire logic                   auxClkPin,
	input  wire logic                   extCnt0Pin,
	input  wire logic                   extCnt1Pin,
	input  wire logic [1:0]             gatePin,
	output logic [`DCTP_PORT_W-1:0]     tpOut,
	output logic [`DCTP_PORT_W-1:0]     tpOe_n,
	output logic                        irq
);
	import dctp_pkg::*;

	dctp_reg_if regBus ();

	logic [`DCTP_PIN_N-1:0]  pinLvl;
	logic [`DCTP_PIN_N-1:0]  pinRise;
	logic [`DCTP_PIN_N-1:0]  pinFall;
	logic [`DCTP_CTRL_W-1:0] ctrl_reg;
	dctp_cnt_t               cnt0_reg;
	dctp_cnt_t               cnt1_reg;
	logic [`DCTP_ST_W-1:0]   status_reg;
	logic [`DCTP_ST_W-1:0]   status_next;
	logic [`DCTP_ST_W-1:0]   mask_reg;
	logic [`DCTP_PORT_W-1:0] pout_reg;
	logic [`DCTP_PORT_W-1:0] poen_reg;
	logic                    irq_reg;
	dctp_mode_e              mode0;
	dctp_src_e               sel0;
	dctp_src_e               sel1;
	logic                    cascade;
	logic                    run0;
	logic                    tick0;
	logic                    tick1;
	logic                    wrCnt0;
	logic                    wrCnt1;
	logic                    ovf0;
	logic                    ovf1;
	logic                    gateEv;
	logic                    rdStat;
	logic [`DCTP_ST_W-1:0]   events;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic src_tick(input dctp_src_e s,
		input logic extRise, input logic auxRise);
		case (s)
		DCTP_SRC_EXT:  src_tick = extRise;
		DCTP_SRC_AUX:  src_tick = auxRise;
		DCTP_SRC_MCLK: src_tick = 1'b1;
		default:       src_tick = 1'b0;
		endcase
	endfunction

	function automatic logic wr_sel(input dctp_addr_t off);
		wr_sel = regBus.wrEn && regBus.wrStrb[0] && regBus.wrAddr == off;
	endfunction

	// ----------------------------------------------------------------
	// bus slave and pin synchronisers
	// ----------------------------------------------------------------
	dctp_axil_slave u_slave
	(
		.clk     (clk),
		.srst    (srst),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.regPort (regBus)
	);

	dctp_pin_sync #(.W(`DCTP_PIN_N)) u_sync
	(
		.clk   (clk),
		.srst  (srst),
		.pinIn ({gatePin[1], gatePin[0], extCnt1Pin, extCnt0Pin,
			auxClkPin}),
		.lvl   (pinLvl),
		.rise  (pinRise),
		.fall  (pinFall)
	);

	// ----------------------------------------------------------------
	// control fields and count enables
	// ----------------------------------------------------------------
	assign mode0   = dctp_mode_e'(ctrl_reg[`DCTP_CTRL_MODE_LSB +: `DCTP_SEL_W]);
	assign sel0    = dctp_src_e'(ctrl_reg[`DCTP_CTRL_SEL0_LSB +: `DCTP_SEL_W]);
	assign sel1    = dctp_src_e'(ctrl_reg[`DCTP_CTRL_SEL1_LSB +: `DCTP_SEL_W]);
	assign cascade = ctrl_reg[`DCTP_CTRL_CASC];
	assign wrCnt0  = wr_sel(`DCTP_OFF_CNT0);
	assign wrCnt1  = wr_sel(`DCTP_OFF_CNT1);

	always_comb
	begin
		case (mode0)
		DCTP_MODE_HALT:  run0 = 1'b0;
		DCTP_MODE_RUN:   run0 = 1'b1;
		DCTP_MODE_GATE0: run0 = pinLvl[`DCTP_PIN_GATE0];
		DCTP_MODE_GATE1: run0 = pinLvl[`DCTP_PIN_GATE1];
		default:         run0 = 1'b0;
		endcase
	end

	// falling end of the selected gate
	assign gateEv = (mode0 == DCTP_MODE_GATE0 && pinFall[`DCTP_PIN_GATE0])
		|| (mode0 == DCTP_MODE_GATE1 && pinFall[`DCTP_PIN_GATE1]);

	assign tick0 = run0 && src_tick(sel0, pinRise[`DCTP_PIN_EXT0],
		pinRise[`DCTP_PIN_AUX]);
	assign ovf0  = tick0 && cnt0_reg == `DCTP_CNT_MAX && !wrCnt0;
	assign tick1 = cascade ? ovf0 : src_tick(sel1, pinRise[`DCTP_PIN_EXT1],
		pinRise[`DCTP_PIN_AUX]);
	assign ovf1  = tick1 && cnt1_reg == `DCTP_CNT_MAX && !wrCnt1;

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			cnt0_reg <= `DCTP_CNT_RST;
		else if (wrCnt0)
			cnt0_reg <= regBus.wrData[`DCTP_CNT_W-1:0];
		else if (tick0)
			cnt0_reg <= cnt0_reg + `DCTP_CNT_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			cnt1_reg <= `DCTP_CNT_RST;
		else if (wrCnt1)
			cnt1_reg <= regBus.wrData[`DCTP_CNT_W-1:0];
		else if (tick1)
			cnt1_reg <= cnt1_reg + `DCTP_CNT_ONE;
	end

	// ----------------------------------------------------------------
	// control, mask and port registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_reg <= `DCTP_CTRL_RST;
			mask_reg <= `DCTP_ST_RST;
		end
		else
		begin
			if (wr_sel(`DCTP_OFF_CTRL))
				ctrl_reg <= regBus.wrData[`DCTP_CTRL_W-1:0];
			if (wr_sel(`DCTP_OFF_MASK))
				mask_reg <= regBus.wrData[`DCTP_ST_W-1:0];
		end
	end

	// output enables kept active low so the pins come straight from flops
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pout_reg <= `DCTP_PORT_RST;
			poen_reg <= `DCTP_OEN_RST;
		end
		else
		begin
			if (wr_sel(`DCTP_OFF_POUT))
				pout_reg <= regBus.wrData[`DCTP_PORT_W-1:0];
			if (wr_sel(`DCTP_OFF_PEN))
				poen_reg <= ~regBus.wrData[`DCTP_PORT_W-1:0];
		end
	end

	assign tpOut  = pout_reg;
	assign tpOe_n = poen_reg;

	// ----------------------------------------------------------------
	// flags and interrupt
	// ----------------------------------------------------------------
	assign rdStat = regBus.rdEn && regBus.rdAddr == `DCTP_OFF_STAT;

	always_comb
	begin
		events                = '0;
		events[`DCTP_ST_GATE] = gateEv;
		events[`DCTP_ST_OVF0] = ovf0 && !cascade;
		events[`DCTP_ST_OVF1] = ovf1;
		// a new event wins over the read clear
		status_next = (rdStat ? `DCTP_ST_RST : status_reg) | events;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			status_reg <= `DCTP_ST_RST;
		else
			status_reg <= status_next;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(status_reg & mask_reg);
	end

	assign irq = irq_reg;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb
	begin
		regBus.rdData = '0;
		case (regBus.rdAddr)
		`DCTP_OFF_CTRL: regBus.rdData[`DCTP_CTRL_W-1:0] = ctrl_reg;
		`DCTP_OFF_CNT0: regBus.rdData[`DCTP_CNT_W-1:0]  = cnt0_reg;
		`DCTP_OFF_CNT1: regBus.rdData[`DCTP_CNT_W-1:0]  = cnt1_reg;
		`DCTP_OFF_STAT: regBus.rdData[`DCTP_ST_W-1:0]   = status_reg;
		`DCTP_OFF_MASK: regBus.rdData[`DCTP_ST_W-1:0]   = mask_reg;
		`DCTP_OFF_POUT: regBus.rdData[`DCTP_PORT_W-1:0] = pout_reg;
		`DCTP_OFF_PEN:  regBus.rdData[`DCTP_PORT_W-1:0] = ~poen_reg;
		default:        regBus.rdData = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence gateEnds;
		gateEv && !wrCnt0;
	endsequence

	sequence lowWraps;
		cascade && ovf0 && !wrCnt1;
	endsequence

	AST_CNT0_MCLK: assert property (
		(mode0 == DCTP_MODE_RUN && sel0 == DCTP_SRC_MCLK && !wrCnt0)
		|=> cnt0_reg == $past(cnt0_reg) + `DCTP_CNT_ONE)
		else $error("counter 0 did not advance on master clock");

	AST_OE_WRITE: assert property (
		regBus.wrEn && regBus.wrStrb[0] && regBus.wrAddr == `DCTP_OFF_PEN
		|=> tpOe_n == ~$past(regBus.wrData[`DCTP_PORT_W-1:0]))
		else $error("output enables do not follow the enable write");

	AST_SRC_OFF: assert property (
		(!cascade && sel1 == DCTP_SRC_OFF && !wrCnt1)
		|=> $stable(cnt1_reg))
		else $error("counter 1 moved with no clock source");

	AST_HALT: assert property (
		(mode0 == DCTP_MODE_HALT && !wrCnt0) |=> $stable(cnt0_reg))
		else $error("halted counter 0 changed");

	AST_GATE_STOP: assert property (
		gateEnds |=> status_reg[`DCTP_ST_GATE]
			&& cnt0_reg == $past(cnt0_reg))
		else $error("gate end did not stop counter or set flag");

	AST_CNT_WRITE: assert property (
		wrCnt1 |=> cnt1_reg == $past(regBus.wrData[`DCTP_CNT_W-1:0]))
		else $error("counter 1 write not taken");

	AST_CASCADE: assert property (
		lowWraps |=> cnt1_reg == $past(cnt1_reg) + `DCTP_CNT_ONE
			&& cnt0_reg == `DCTP_CNT_RST)
		else $error("cascade carry missing");

	AST_IRQ: assert property (
		irq == $past(|(status_reg & mask_reg)))
		else $error("interrupt does not follow the unmasked flags");

	AST_OVF0_SEP: assert property (
		(!cascade && ovf0) |=> status_reg[`DCTP_ST_OVF0])
		else $error("counter 0 overflow flag missing");

	AST_OVF0_CASC: assert property (
		(cascade && !status_reg[`DCTP_ST_OVF0])
		|=> !status_reg[`DCTP_ST_OVF0])
		else $error("low overflow flagged in cascade mode");

	AST_WRAP1: assert property (
		(ovf1 && !wrCnt1)
		|=> cnt1_reg == `DCTP_CNT_RST && status_reg[`DCTP_ST_OVF1])
		else $error("counter 1 did not wrap to zero with flag");
endmodule

`default_nettype wire

/* File: hw/dctp_map.svh */
// register offsets, field positions and reset values of the timer port
`ifndef DCTP_MAP_SVH
`define DCTP_MAP_SVH

`define DCTP_AW            8
`define DCTP_DW            32
`define DCTP_SW            4
`define DCTP_CNT_W         8
`define DCTP_PORT_W        6
`define DCTP_ST_W          3
`define DCTP_CTRL_W        7
`define DCTP_SEL_W         2

`define DCTP_OFF_CTRL      8'h00
`define DCTP_OFF_CNT0      8'h04
`define DCTP_OFF_CNT1      8'h08
`define DCTP_OFF_STAT      8'h0C
`define DCTP_OFF_MASK      8'h10
`define DCTP_OFF_POUT      8'h14
`define DCTP_OFF_PEN       8'h18

`define DCTP_CTRL_MODE_LSB 0
`define DCTP_CTRL_SEL0_LSB 2
`define DCTP_CTRL_SEL1_LSB 4
`define DCTP_CTRL_CASC     6

`define DCTP_ST_GATE       0
`define DCTP_ST_OVF0       1
`define DCTP_ST_OVF1       2

`define DCTP_PIN_N         5
`define DCTP_PIN_AUX       0
`define DCTP_PIN_EXT0      1
`define DCTP_PIN_EXT1      2
`define DCTP_PIN_GATE0     3
`define DCTP_PIN_GATE1     4

`define DCTP_CTRL_RST      7'h00
`define DCTP_CNT_RST       8'h00
`define DCTP_CNT_MAX       8'hFF
`define DCTP_CNT_ONE       8'h01
`define DCTP_ST_RST        3'h0
`define DCTP_PORT_RST      6'h00
`define DCTP_OEN_RST       6'h3F

`define DCTP_RESP_OKAY     2'h0
`define DCTP_RESP_SLVERR   2'h2

`endif

/* File: hw/dctp_pkg.sv */
// types and address decode shared by the timer port modules
`include "dctp_map.svh"

package dctp_pkg;

	typedef logic [`DCTP_AW-1:0]    dctp_addr_t;
	typedef logic [`DCTP_DW-1:0]    dctp_data_t;
	typedef logic [`DCTP_SW-1:0]    dctp_strb_t;
	typedef logic [`DCTP_CNT_W-1:0] dctp_cnt_t;

	typedef enum logic [`DCTP_SEL_W-1:0]
	{
		DCTP_SRC_EXT,
		DCTP_SRC_AUX,
		DCTP_SRC_MCLK,
		DCTP_SRC_OFF
	} dctp_src_e;

	typedef enum logic [`DCTP_SEL_W-1:0]
	{
		DCTP_MODE_HALT,
		DCTP_MODE_RUN,
		DCTP_MODE_GATE0,
		DCTP_MODE_GATE1
	} dctp_mode_e;

	function automatic logic dctp_reg_hit(input dctp_addr_t a);
		case (a)
		`DCTP_OFF_CTRL, `DCTP_OFF_CNT0, `DCTP_OFF_CNT1, `DCTP_OFF_STAT,
		`DCTP_OFF_MASK, `DCTP_OFF_POUT, `DCTP_OFF_PEN:
			dctp_reg_hit = 1'b1;
		default:
			dctp_reg_hit = 1'b0;
		endcase
	endfunction

endpackage

/* File: hw/dctp_reg_if.sv */
// register access carrier between the bus slave and the timer core
`timescale 1ns/1ps
`default_nettype none

interface dctp_reg_if;
	logic                wrEn;
	dctp_pkg::dctp_addr_t wrAddr;
	dctp_pkg::dctp_data_t wrData;
	dctp_pkg::dctp_strb_t wrStrb;
	logic                rdEn;
	dctp_pkg::dctp_addr_t rdAddr;
	dctp_pkg::dctp_data_t rdData;

	modport bus
	(
		output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
		input  rdData
	);
	modport core
	(
		input  wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
		output rdData
	);
endinterface

`default_nettype wire

/* File: hw/dctp_pin_sync.sv */
// two-stage synchroniser with level and edge outputs for external pins
`timescale 1ns/1ps
`default_nettype none

module dctp_pin_sync
#(
	parameter int W = `DCTP_PIN_N
)
(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	import dctp_pkg::*;

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] prev_reg;

	// first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end
		else
		begin
			meta_reg <= pinIn;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign lvl  = sync_reg;
	assign rise = sync_reg & ~prev_reg;
	assign fall = ~sync_reg & prev_reg;
endmodule

`default_nettype wire

/* File: hw/dctp_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none

module dctp_axil_slave
(
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire dctp_pkg::dctp_addr_t awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire dctp_pkg::dctp_data_t wdata,
	input  wire dctp_pkg::dctp_strb_t wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire dctp_pkg::dctp_addr_t araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output dctp_pkg::dctp_data_t      rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	dctp_reg_if.bus                   regPort
);
	import dctp_pkg::*;

	logic       awHeld_reg;
	logic       wHeld_reg;
	dctp_addr_t awAddr_reg;
	dctp_data_t wData_reg;
	dctp_strb_t wStrb_reg;
	logic       doWrite;
	logic       arTake;

	// ----------------------------------------------------------------
	// write channel: address and data in either order
	// ----------------------------------------------------------------
	assign doWrite = awHeld_reg && wHeld_reg && !bvalid;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			awAddr_reg <= '0;
			wData_reg  <= '0;
			wStrb_reg  <= '0;
			awready    <= 1'b0;
			wready     <= 1'b0;
			bvalid     <= 1'b0;
			bresp      <= `DCTP_RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awAddr_reg <= awaddr;
				awHeld_reg <= 1'b1;
				awready    <= 1'b0;
			end
			else if (!awHeld_reg && !bvalid)
				awready <= 1'b1;
			if (wvalid && wready)
			begin
				wData_reg <= wdata;
				wStrb_reg <= wstrb;
				wHeld_reg <= 1'b1;
				wready    <= 1'b0;
			end
			else if (!wHeld_reg && !bvalid)
				wready <= 1'b1;
			if (doWrite)
			begin
				awHeld_reg <= 1'b0;
				wHeld_reg  <= 1'b0;
				bvalid     <= 1'b1;
				bresp      <= dctp_reg_hit(awAddr_reg) ?
					`DCTP_RESP_OKAY : `DCTP_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	assign regPort.wrEn   = doWrite && dctp_reg_hit(awAddr_reg);
	assign regPort.wrAddr = awAddr_reg;
	assign regPort.wrData = wData_reg;
	assign regPort.wrStrb = wStrb_reg;

	// ----------------------------------------------------------------
	// read channel: data captured at the address handshake
	// ----------------------------------------------------------------
	assign arTake         = arvalid && arready;
	assign regPort.rdEn   = arTake;
	assign regPort.rdAddr = araddr;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `DCTP_RESP_OKAY;
		end
		else
		begin
			if (arTake)
			begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= dctp_reg_hit(araddr) ? regPort.rdData : '0;
				rresp   <= dctp_reg_hit(araddr) ?
					`DCTP_RESP_OKAY : `DCTP_RESP_SLVERR;
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
			else if (!rvalid)
				arready <= 1'b1;
		end
	end
endmodule

`default_nettype wire

/* File: sim/dctp_pin_model.sv */
// external count, aux clock and gate sources driving the timer port pins
`timescale 1ns/1ps
`default_nettype none

module dctp_pin_model
(
	input  wire logic  clk,
	output logic       auxClkPin,
	output logic       extCnt0Pin,
	output logic       extCnt1Pin,
	output logic [1:0] gatePin
);
	initial
	begin
		auxClkPin  = 1'b0;
		extCnt0Pin = 1'b0;
		extCnt1Pin = 1'b0;
		gatePin    = 2'h0;
	end

	// 0 aux, 1 count pin 0, 2 count pin 1
	task automatic setPin(input int idx, input logic v);
		case (idx)
		0: auxClkPin <= v;
		1: extCnt0Pin <= v;
		default: extCnt1Pin <= v;
		endcase
	endtask

	// each level held three clocks so the synchroniser never misses it
	task automatic pulse(input int idx, input int n);
		repeat (n)
		begin
			setPin(idx, 1'b1);
			repeat (3) @(posedge clk);
			setPin(idx, 1'b0);
			repeat (3) @(posedge clk);
		end
	endtask

	task automatic gate(input int idx, input logic v);
		gatePin[idx] <= v;
		@(posedge clk);
	endtask
endmodule

`default_nettype wire

/* File: sim/dctp_timer_port_tb_top.sv */
// self-checking bench for the dual counter timer port
`timescale 1ns/1ps
`default_nettype none

module dctp_timer_port_tb_top;
	import dctp_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam dctp_addr_t ACTL = 8'h00, ACN0 = 8'h04, ACN1 = 8'h08;
	localparam dctp_addr_t AST = 8'h0C, AMK = 8'h10, APO = 8'h14;
	localparam dctp_addr_t APE = 8'h18;
	logic       clk, srst, awvalid, awready, wvalid, wready, bvalid;
	logic       bready, arvalid, arready, rvalid, rready, irq;
	logic       auxClkPin, extCnt0Pin, extCnt1Pin;
	logic [1:0] gatePin, bresp, rresp;
	logic [5:0] tpOut, tpOe_n;
	dctp_addr_t awaddr, araddr;
	dctp_data_t wdata, rdata;
	dctp_strb_t wstrb;
	int         errors, checksDone, cycles;

	dctp_timer_port dut
	(
		.clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.auxClkPin(auxClkPin), .extCnt0Pin(extCnt0Pin),
		.extCnt1Pin(extCnt1Pin), .gatePin(gatePin), .tpOut(tpOut),
		.tpOe_n(tpOe_n), .irq(irq)
	);

	dctp_pin_model pins
	(
		.clk(clk), .auxClkPin(auxClkPin), .extCnt0Pin(extCnt0Pin),
		.extCnt1Pin(extCnt1Pin), .gatePin(gatePin)
	);

	always #2.5 clk = ~clk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checksDone++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ready and valid are looked at mid-cycle, where they hold the value
	// that the next rising edge samples
	task automatic wr(input dctp_addr_t a, input dctp_data_t d,
		input dctp_strb_t s = 4'hF, input logic [1:0] r = 2'h0);
		logic aw, w;
		logic [1:0] br;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(negedge clk);
			aw = awvalid && awready;
			w  = wvalid && wready;
			br = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		do
		begin
			@(negedge clk);
			aw = bvalid;
			br = bresp;
			@(posedge clk);
		end while (!aw);
		bready <= 1'b0;
		chk($sformatf("bresp %h", a), 32'(br), 32'(r));
		// one edge passes so a following call never reassigns bready
		@(posedge clk);
	endtask

	task automatic rd(input dctp_addr_t a, output dctp_data_t d,
		output logic [1:0] r);
		logic hit;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(negedge clk);
			hit = arready;
			@(posedge clk);
		end while (!hit);
		arvalid <= 1'b0;
		do
		begin
			@(negedge clk);
			hit = rvalid;
			d   = rdata;
			r   = rresp;
			@(posedge clk);
		end while (!hit);
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdChk(input dctp_addr_t a, input dctp_data_t e,
		input logic [1:0] er = 2'h0);
		dctp_data_t d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("rdata %h", a), d, e);
		chk($sformatf("rresp %h", a), 32'(r), 32'(er));
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic tReset();
		for (int i = 0; i < 7; i++)
			rdChk(8'(4 * i), 32'h0);
		rdChk(8'h1C, 32'h0, 2'h2);
		chk("tpOe_n", 32'(tpOe_n), 32'h3F);
		chk("tpOut", 32'(tpOut), 32'h0);
		chk("irq", 32'(irq), 32'h0);
		$display("test reset done");
	endtask

	task automatic tPort();
		wr(APO, 32'h2A);
		wr(APE, 32'h0F);
		idle(2);
		chk("tpOut", 32'(tpOut), 32'h2A);
		chk("tpOe_n", 32'(tpOe_n), 32'h30);
		wr(APO, 32'h15, 4'hE);
		rdChk(APO, 32'h2A);
		wr(8'h1C, 32'h1, 4'hF, 2'h2);
		wr(AST, 32'h7);
		rdChk(AST, 32'h0);
		$display("test port done");
	endtask

	task automatic tCount0();
		wr(ACTL, 32'h01);
		wr(ACN0, 32'hFE);
		pins.pulse(1, 3);
		idle(4);
		rdChk(ACN0, 32'h01);
		rdChk(AST, 32'h02);
		rdChk(AST, 32'h00);
		$display("test count0 done");
	endtask

	task automatic tCount1();
		dctp_data_t d;
		logic [1:0] r;
		wr(ACN0, 32'h55);
		wr(ACTL, 32'h10); // counter 0 halted, counter 1 from aux
		wr(ACN1, 32'hFF);
		pins.pulse(0, 2);
		pins.pulse(1, 2);
		pins.pulse(2, 2);
		idle(4);
		rdChk(ACN1, 32'h01);
		rdChk(ACN0, 32'h55);
		rdChk(AST, 32'h04);
		wr(ACTL, 32'h00);
		pins.pulse(2, 1);
		idle(4);
		rdChk(ACN1, 32'h02);
		wr(ACTL, 32'h29); // both counters on the master clock
		wr(ACTL, 32'h30);
		rd(ACN1, d, r);
		rdChk(ACN1, d);
		chk("master clock count", 32'(d > 32'h02), 32'h1);
		rd(ACN0, d, r);
		rdChk(ACN0, d);
		chk("master clock count0", 32'(d > 32'h55), 32'h1);
		$display("test count1 done");
	endtask

	task automatic tGate();
		for (int g = 0; g < 2; g++)
		begin
			wr(ACN0, 32'h00);
			wr(ACTL, 32'(2 + g));
			pins.gate(g, 1'b1);
			pins.pulse(1, 2);
			pins.gate(g, 1'b0);
			idle(4);
			pins.pulse(1, 2);
			idle(4);
			rdChk(ACN0, 32'h02);
			rdChk(AST, 32'h01);
		end
		$display("test gate done");
	endtask

	task automatic tCascade();
		wr(ACTL, 32'h41);
		wr(ACN1, 32'hFF);
		wr(ACN0, 32'hFF);
		pins.pulse(1, 1);
		idle(4);
		rdChk(ACN0, 32'h00);
		rdChk(ACN1, 32'h00);
		rdChk(AST, 32'h04);
		wr(ACN0, 32'hFF);
		pins.pulse(1, 1);
		idle(4);
		rdChk(ACN1, 32'h01);
		rdChk(AST, 32'h00);
		$display("test cascade done");
	endtask

	task automatic tIrq();
		wr(ACTL, 32'h01);
		wr(AMK, 32'h02);
		wr(ACN0, 32'hFF);
		pins.pulse(1, 1);
		idle(4);
		chk("irq", 32'(irq), 32'h1);
		wr(AMK, 32'h05);
		idle(2);
		chk("irq", 32'(irq), 32'h0);
		rdChk(AMK, 32'h05);
		wr(AMK, 32'h02);
		idle(2);
		chk("irq", 32'(irq), 32'h1);
		rdChk(AST, 32'h02);
		idle(2);
		chk("irq", 32'(irq), 32'h0);
		$display("test irq done");
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			end_of_test();
		end
	end

	initial
	begin
		clk = 1'b0;
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		tReset();
		tPort();
		tCount0();
		tCount1();
		tGate();
		tCascade();
		tIrq();
		end_of_test();
	end
endmodule

`default_nettype wire
